//--- pkg/regctl_defines.svh
/*
 * Register offsets, field positions and reset constants for the
 * regulator voltage control register bank.
 * Assumes it is included by its bare name from the package only; the
 * design files use its macros through that include; it holds definitions only.
 */
// What this block does
// [RULE_01] The low six bits of the ceiling register hold the highest code allowed for regulator_b.
// [RULE_02] A code above the ceiling written to a governed regulator_b setting is ignored.
// [RULE_03] The ceiling register ignores writes unless its field is all zeros or all ones.
// [RULE_04] Bit 6 of the primary register picks the primary (0) or alternate (1) code as output.
// [RULE_05] Each voltage-setting register holds a six-bit code in bits 5 to 0.
// [RULE_06] Bit 7 of the alternate register switches regulator_c off at 0 and on at 1.
// [RULE_07] A sequence-controlled enable default turns regulator_c on during power-up sequencing.
// [RULE_08] Bit 6 of the alternate register selects power-save mode when set, normal when clear.
// [RULE_09] Power-on reset restores all three registers, voltage fields and enable from OTP.
// [RULE_10] Primary bit 7 and ceiling bits 7 and 6 are reserved, read-only and read as zero.
// [RULE_11] Host software writes zero to reserved bits and expects zero back from them.
`ifndef REGCTL_DEFINES_SVH
`define REGCTL_DEFINES_SVH

// Register offsets on the serial control register port
`define ADDR_B_CEILING 8'h15
`define ADDR_C_PRIMARY 8'h16
`define ADDR_C_ALTERNATE 8'h17

// Field positions
`define CODE_MSB 5
`define CODE_LSB 0
`define SRC_SEL_BIT 6
`define LOW_POWER_BIT 6
`define ENABLE_BIT 7

// Special ceiling values that keep the ceiling writable
`define CEIL_OPEN_LOW 6'h00
`define CEIL_OPEN_HIGH 6'h3f

// Constant values held during reset, before the OTP load, and zero fill for read-back
`define RST_CODE 6'h00
`define RST_BIT 1'h0
`define RST_BYTE 8'h00
`define ZERO_BYTE 8'h00
`define ZERO_PAD 2'h0

`endif

//--- pkg/regctl_pkg.sv
/*
 * Types shared by the regulator voltage control register bank.
 * Assumes regctl_defines.svh is on the include path.
 */
package regctl_pkg;
    `include "regctl_defines.svh"

    typedef logic [5:0] vcode_t;
    typedef logic [7:0] reg_byte_t;

    // Load sequence after power-on reset
    typedef enum logic {
        LOAD_OTP,
        RUNNING
    } load_state_t;
endpackage

//--- rtl/reg_field.sv
/*
 * One storage field with asynchronous reset to a constant, a one-time
 * load from OTP, and a qualified software write.
 * Assumes the caller gates the write with its own acceptance terms.
 */
module reg_field #(
    parameter int W = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // OTP load
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    // Software write
    input wire logic wr_i,
    input wire logic [W-1:0] wr_val_i,
    // Stored value
    output logic [W-1:0] q_o
);
    logic [W-1:0] next_q;

    // Load takes priority over a write in the same cycle
    assign next_q = load_i ? load_val_i : (wr_i ? wr_val_i : q_o);

    // Storage, frozen while the clock enable is low
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q_o <= RST_VAL;
        end else if (ce_i) begin
            q_o <= next_q;
        end
    end
endmodule

//--- rtl/regulator_voltage_ctrl_regs.sv
/*
 * Register bank controlling regulator_b's voltage ceiling and
 * regulator_c's primary and alternate voltage settings, enable and
 * low-power mode.
 * Assumes a simple synchronous register port from the serial control
 * interface, and OTP default values that are stable from reset release
 * until the first enabled clock edge after it.
 */
module regulator_voltage_ctrl_regs (
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Register port from the serial control interface
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // OTP defaults
    input wire regctl_pkg::vcode_t otp_b_ceiling_i,
    input wire regctl_pkg::vcode_t otp_c_primary_code_i,
    input wire regctl_pkg::vcode_t otp_c_alternate_code_i,
    input wire logic otp_c_enable_i,
    input wire logic otp_c_enable_by_seq_i,
    // Power-up sequencer step for regulator_c
    input wire logic seq_c_power_up_i,
    // Ceiling check for regulator_b setting writes
    input wire regctl_pkg::vcode_t regulator_b_candidate_code_i,
    output logic regulator_b_code_allowed_o,
    output regctl_pkg::vcode_t regulator_b_ceiling_o,
    // Regulator_c controls
    output regctl_pkg::vcode_t regulator_c_code_o,
    output logic regulator_c_enable_o,
    output logic regulator_c_low_power_o,
    // Load status
    output logic otp_load_done_o
);
    import regctl_pkg::*;

    load_state_t load_state;
    load_state_t next_load_state;
    logic load_now;

    // Stored fields
    vcode_t b_ceiling;
    vcode_t c_primary_code;
    logic c_source_select;
    vcode_t c_alternate_code;
    logic c_low_power;
    logic c_enable;

    // Address decode and write strobes
    logic hit_ceiling;
    logic hit_primary;
    logic hit_alternate;
    logic wr_ok;
    logic wr_ceiling;
    logic wr_primary;
    logic wr_alternate;
    logic ceiling_open;

    // Enable bit handling
    logic c_enable_seq_ctrl;
    logic next_c_enable;
    logic c_enable_load_val;

    // Selected output code and read mux
    vcode_t next_c_code;
    reg_byte_t read_value;
    reg_byte_t ceiling_view;
    reg_byte_t primary_view;
    reg_byte_t alternate_view;

    // Load sequencer: one OTP load at the first enabled edge after reset
    always_comb begin
        next_load_state = load_state;
        case (load_state)
            LOAD_OTP: next_load_state = RUNNING;
            RUNNING: next_load_state = RUNNING;
            default: next_load_state = LOAD_OTP;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            load_state <= LOAD_OTP;
        end else if (ce_i) begin
            load_state <= next_load_state;
        end
    end

    assign load_now = (load_state == LOAD_OTP); // [RULE_09]
    assign otp_load_done_o = (load_state == RUNNING);

    // Address decoding; writes are refused while the OTP load is pending
    assign hit_ceiling = (reg_addr_i == `ADDR_B_CEILING);
    assign hit_primary = (reg_addr_i == `ADDR_C_PRIMARY);
    assign hit_alternate = (reg_addr_i == `ADDR_C_ALTERNATE);
    assign wr_ok = reg_wr_i && !load_now;

    // The ceiling accepts writes only while it sits at an open value
    assign ceiling_open = (b_ceiling == `CEIL_OPEN_LOW) ||
                          (b_ceiling == `CEIL_OPEN_HIGH); // [RULE_03]
    assign wr_ceiling = wr_ok && hit_ceiling && ceiling_open; // [RULE_03]
    assign wr_primary = wr_ok && hit_primary;
    assign wr_alternate = wr_ok && hit_alternate;

    // Ceiling for regulator_b, low six bits of its register
    reg_field #(
        .W(6),
        .RST_VAL(`RST_CODE)
    ) u_b_ceiling (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .load_i(load_now),
        .load_val_i(otp_b_ceiling_i),
        .wr_i(wr_ceiling),
        .wr_val_i(reg_wdata_i[`CODE_MSB:`CODE_LSB]), // [RULE_01]
        .q_o(b_ceiling)
    );

    // Ceiling check for regulator_b setting writes done elsewhere
    assign regulator_b_code_allowed_o =
        (regulator_b_candidate_code_i <= b_ceiling); // [RULE_02]
    assign regulator_b_ceiling_o = b_ceiling; // [RULE_01]

    // Regulator_c primary voltage code
    reg_field #(
        .W(6),
        .RST_VAL(`RST_CODE)
    ) u_c_primary_code (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .load_i(load_now),
        .load_val_i(otp_c_primary_code_i),
        .wr_i(wr_primary),
        .wr_val_i(reg_wdata_i[`CODE_MSB:`CODE_LSB]), // [RULE_05]
        .q_o(c_primary_code)
    );

    // Regulator_c setting source select, cleared by the OTP load
    reg_field #(
        .W(1),
        .RST_VAL(`RST_BIT)
    ) u_c_source_select (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .load_i(load_now),
        .load_val_i(`RST_BIT),
        .wr_i(wr_primary),
        .wr_val_i(reg_wdata_i[`SRC_SEL_BIT]), // [RULE_04]
        .q_o(c_source_select)
    );

    // Regulator_c alternate voltage code
    reg_field #(
        .W(6),
        .RST_VAL(`RST_CODE)
    ) u_c_alternate_code (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .load_i(load_now),
        .load_val_i(otp_c_alternate_code_i),
        .wr_i(wr_alternate),
        .wr_val_i(reg_wdata_i[`CODE_MSB:`CODE_LSB]), // [RULE_05]
        .q_o(c_alternate_code)
    );

    // Regulator_c low-power mode, normal mode after reset
    reg_field #(
        .W(1),
        .RST_VAL(`RST_BIT)
    ) u_c_low_power (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .load_i(load_now),
        .load_val_i(`RST_BIT),
        .wr_i(wr_alternate),
        .wr_val_i(reg_wdata_i[`LOW_POWER_BIT]), // [RULE_08]
        .q_o(c_low_power)
    );

    // Enable default: a sequence-controlled part starts off and waits
    assign c_enable_load_val = otp_c_enable_by_seq_i ? `RST_BIT : otp_c_enable_i;

    // Enable next value; the sequencer's switch-on wins over a host clear
    always_comb begin
        next_c_enable = c_enable;
        if (load_now) begin
            next_c_enable = c_enable_load_val; // [RULE_09]
        end else if (c_enable_seq_ctrl && seq_c_power_up_i) begin
            next_c_enable = 1'b1; // [RULE_07]
        end else if (wr_alternate) begin
            next_c_enable = reg_wdata_i[`ENABLE_BIT]; // [RULE_06]
        end
    end

    // Enable bit and the latched sequence-control flag from OTP
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            c_enable <= `RST_BIT;
            c_enable_seq_ctrl <= `RST_BIT;
        end else if (ce_i) begin
            c_enable <= next_c_enable;
            if (load_now) begin
                c_enable_seq_ctrl <= otp_c_enable_by_seq_i;
            end
        end
    end

    // Output code chosen by the source-select bit
    assign next_c_code = c_source_select ? c_alternate_code : c_primary_code; // [RULE_04]

    // Regulator_c controls come from flip-flops
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            regulator_c_code_o <= `RST_CODE;
            regulator_c_enable_o <= `RST_BIT;
            regulator_c_low_power_o <= `RST_BIT;
        end else if (ce_i) begin
            regulator_c_code_o <= next_c_code;
            regulator_c_enable_o <= c_enable; // [RULE_06]
            regulator_c_low_power_o <= c_low_power; // [RULE_08]
        end
    end

    // Register images as read back; reserved bits read as zero
    assign ceiling_view = {`ZERO_PAD, b_ceiling}; // [RULE_10]
    assign primary_view = {1'b0, c_source_select, c_primary_code}; // [RULE_10]
    assign alternate_view = {c_enable, c_low_power, c_alternate_code};

    // Read select; unmapped addresses read as zero
    assign read_value = hit_ceiling ? ceiling_view :
                        hit_primary ? primary_view :
                        hit_alternate ? alternate_view : `ZERO_BYTE;

    // Read data registered one cycle after the read strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= `RST_BYTE;
            reg_rvalid_o <= `RST_BIT;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= read_value;
            end
        end
    end
endmodule

//--- bench/regulator_voltage_ctrl_regs_monitor.sv
/* Checker for the regulator control register bank.
   Assumes it is bound to the bank and sees only its ports. */
module regulator_voltage_ctrl_regs_monitor (
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    // Controls and status
    input wire logic otp_c_enable_by_seq_i,
    input wire logic seq_c_power_up_i,
    input wire regctl_pkg::vcode_t regulator_b_candidate_code_i,
    input wire logic regulator_b_code_allowed_o,
    input wire regctl_pkg::vcode_t regulator_b_ceiling_o,
    input wire regctl_pkg::vcode_t regulator_c_code_o,
    input wire logic regulator_c_enable_o,
    input wire logic regulator_c_low_power_o,
    input wire logic otp_load_done_o
);
    import regctl_pkg::*;
    // One clock domain for every property
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Ceiling that no longer takes writes
    wire logic locked = regulator_b_ceiling_o != 6'h00 && regulator_b_ceiling_o != 6'h3f;
    wire logic quiet = otp_load_done_o && !reg_wr_i;
    // Properties and their checks
    property p_allow;
        regulator_b_code_allowed_o == (regulator_b_candidate_code_i <= regulator_b_ceiling_o);
    endproperty
    a_allow: assert property (p_allow) else $error("ceiling check wrong");
    property p_lock; otp_load_done_o && locked |=> $stable(regulator_b_ceiling_o); endproperty
    a_lock: assert property (p_lock) else $error("locked ceiling moved");
    // Regulator_c outputs trail their fields by one edge, so two quiet edges are needed
    property p_code; quiet && $past(quiet) |=> $stable(regulator_c_code_o); endproperty
    a_code: assert property (p_code) else $error("code moved unwritten");
    property p_en;
        quiet && $past(quiet) && !seq_c_power_up_i && !$past(seq_c_power_up_i)
            |=> $stable(regulator_c_enable_o);
    endproperty
    a_en: assert property (p_en) else $error("enable moved unwritten");
    property p_lp; quiet && $past(quiet) |=> $stable(regulator_c_low_power_o); endproperty
    a_lp: assert property (p_lp) else $error("low power moved unwritten");
    property p_load; !otp_load_done_o && ce_i |=> otp_load_done_o; endproperty
    a_load: assert property (p_load) else $error("load late");
    property p_seq;
        otp_load_done_o && otp_c_enable_by_seq_i && seq_c_power_up_i && ce_i
            |=> ##1 regulator_c_enable_o;
    endproperty
    a_seq: assert property (p_seq) else $error("sequencer did not enable");
    property p_rsv;
        reg_rvalid_o && $past(reg_addr_i) == 8'h15 |-> reg_rdata_o[7:6] == 2'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    // Main scenarios reached
    c_seq: cover property (otp_load_done_o && seq_c_power_up_i);
    c_lock: cover property (reg_wr_i && reg_addr_i == 8'h15 && locked);
    c_read: cover property (reg_rvalid_o);
endmodule

bind regulator_voltage_ctrl_regs regulator_voltage_ctrl_regs_monitor mon_i (.clk_i, .sys_rst_i,
    .ce_i, .reg_addr_i, .reg_wr_i, .reg_rdata_o, .reg_rvalid_o, .otp_c_enable_by_seq_i,
    .seq_c_power_up_i, .regulator_b_candidate_code_i, .regulator_b_code_allowed_o,
    .regulator_b_ceiling_o, .regulator_c_code_o, .regulator_c_enable_o,
    .regulator_c_low_power_o, .otp_load_done_o);

//--- bench/host_model.sv
/* Host model driving the register port as host software would.
   Assumes the bench calls its tasks; signals move at falling edges. */
module host_model (
    // Clock
    input wire logic clk_i,
    // Register port
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // One write, reserved bits cleared; lines scrambled once released
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 8'h15) ? 8'h3f : (a == 8'h16) ? 8'h7f : 8'hff;
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d & m;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    // One read; answer taken one cycle after the strobe
    task automatic get(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        ok = rvalid_i;
        d = rdata_i;
    endtask
endmodule

//--- bench/tb_regulator_voltage_ctrl_regs.sv
/* Bench for the regulator control register bank.
   Assumes package, design, checker and host model compile first. */
module tb_regulator_voltage_ctrl_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import regctl_pkg::*;
    `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
        $display("[ERR] %s expected %h seen %h", n, e, g); end end
    // Stimulus and observed signals
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, ok;
    vcode_t otp_b_ceiling_i = 6'h3f;
    vcode_t otp_c_primary_code_i = 6'h27;
    vcode_t otp_c_alternate_code_i = 6'h10;
    logic otp_c_enable_i = 1'b1;
    logic otp_c_enable_by_seq_i = 1'b0;
    logic seq_c_power_up_i = 1'b0;
    vcode_t regulator_b_candidate_code_i = 6'h00;
    vcode_t regulator_b_ceiling_o, regulator_c_code_o;
    logic regulator_b_code_allowed_o, regulator_c_enable_o, regulator_c_low_power_o;
    logic otp_load_done_o;
    int bad_count = 0;
    int samples_checked = 0;
    // 125 MHz clock
    always #4 clk_i = ~clk_i;
    // Host side and the bank
    host_model host_model_i (.clk_i, .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
        .wr_o(reg_wr_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));
    regulator_voltage_ctrl_regs regulator_voltage_ctrl_regs_i (.clk_i, .sys_rst_i, .ce_i,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
        .otp_b_ceiling_i, .otp_c_primary_code_i, .otp_c_alternate_code_i, .otp_c_enable_i,
        .otp_c_enable_by_seq_i, .seq_c_power_up_i, .regulator_b_candidate_code_i,
        .regulator_b_code_allowed_o, .regulator_b_ceiling_o, .regulator_c_code_o,
        .regulator_c_enable_o, .regulator_c_low_power_o, .otp_load_done_o);
    // Verdict and end of run
    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reset for four cycles, then a bounded wait for the default load
    task automatic do_reset(input logic by_seq);
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        otp_c_enable_by_seq_i = by_seq;
        repeat (4) @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 8 && otp_load_done_o !== 1'b1; i++) @(negedge clk_i);
        if (otp_load_done_o !== 1'b1) begin
            `CHK("load_done", 1'b1, otp_load_done_o)
            wrap_up();
        end
        @(negedge clk_i);
    endtask
    // Read and compare one register
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host_model_i.get(a, rv, ok);
        `CHK("rvalid", 1'b1, ok)
        `CHK("rdata", e, rv)
    endtask
    // Defaults after power-on reset, unmapped read
    task automatic t_load();
        rd_chk(8'h15, 8'h3f);
        rd_chk(8'h16, 8'h27);
        rd_chk(8'h17, 8'h90);
        rd_chk(8'h20, 8'h00);
        `CHK("code", 6'h27, regulator_c_code_o)
        `CHK("enable", 1'b1, regulator_c_enable_o)
        `CHK("low_power", 1'b0, regulator_c_low_power_o)
    endtask
    // Open ceiling takes one write, then locks; candidate checked 1 ns after a falling edge
    task automatic t_ceiling();
        host_model_i.put(8'h15, 8'h0a);
        rd_chk(8'h15, 8'h0a);
        `CHK("ceiling", 6'h0a, regulator_b_ceiling_o)
        regulator_b_candidate_code_i = 6'h0a;
        #1 `CHK("allowed", 1'b1, regulator_b_code_allowed_o)
        @(negedge clk_i);
        regulator_b_candidate_code_i = 6'h0b;
        #1 `CHK("allowed", 1'b0, regulator_b_code_allowed_o)
        host_model_i.put(8'h15, 8'h3f);
        rd_chk(8'h15, 8'h0a);
    endtask
    // Source select, then alternate fields
    task automatic t_select();
        host_model_i.put(8'h16, 8'h45);
        @(negedge clk_i);
        `CHK("code", 6'h10, regulator_c_code_o)
        rd_chk(8'h16, 8'h45);
        host_model_i.put(8'h17, 8'h7c);
        @(negedge clk_i);
        `CHK("code", 6'h3c, regulator_c_code_o)
        `CHK("enable", 1'b0, regulator_c_enable_o)
        `CHK("low_power", 1'b1, regulator_c_low_power_o)
    endtask
    // A write while the clock enable is low leaves the register untouched
    task automatic t_freeze();
        ce_i = 1'b0;
        host_model_i.put(8'h17, 8'hc1);
        ce_i = 1'b1;
        rd_chk(8'h17, 8'h7c);
        `CHK("low_power", 1'b1, regulator_c_low_power_o)
    endtask
    // Sequence-controlled enable waits for the sequencer step
    task automatic t_seq();
        `CHK("enable", 1'b0, regulator_c_enable_o)
        seq_c_power_up_i = 1'b1;
        @(negedge clk_i);
        seq_c_power_up_i = 1'b0;
        @(negedge clk_i);
        `CHK("enable", 1'b1, regulator_c_enable_o)
    endtask
    // Main sequence
    initial begin
        do_reset(1'b0);
        t_load();
        t_ceiling();
        t_select();
        t_freeze();
        do_reset(1'b1);
        t_seq();
        wrap_up();
    end
endmodule
